//--- isf_status.sv
// Status flags of a two-wire serial bus controller with Avalon-MM access
//
// How it works
// - Transfer-complete sets on the falling edge of the ninth serial clock.
// - Transfer-complete stays cleared while a byte is shifting.
// - Addressed-as-slave sets when the calling address equals own address.
// - A control register write clears addressed-as-slave unless an address match sets it in that cycle.
// - An address match interrupts the processor when interrupts are enabled.
// - START sets bus busy, STOP clears it; 1 means busy.
// - Data low while driven high in transmit or receive ack loses arbitration.
// - START on busy bus, slave repeated START, unrequested STOP lose arbitration.
// - Address byte direction bit is captured as slave read/write when matched.
// - Pending interrupt sets on byte done, address match and arbitration loss.
// - Pending interrupt clears only by software writing 0 to it.
// - Interrupt request is high while pending and interrupt enable are 1.
// - Received-ack records 0 for acknowledge, 1 for none at ninth clock.
// - Upper status bits and bit 3 read as zero.
// - Clearing interrupt enable leaves pending conditions set.
// - Transmit/receive select gives direction for master and slave: 1 transmit.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module isf_status import isf_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_drive_high,
    output logic irq,
    output logic ctl_enable,
    output logic ctl_master,
    output logic ctl_tx_select,
    output logic ctl_txak,
    output logic repeat_start
);

    typedef struct packed {
        isf_phase_t phase;
        logic scl_prev;
        logic sda_prev;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic ack_sample;
        logic [7:0] own_addr;
        logic enable;
        logic int_en;
        logic master;
        logic tx_sel;
        logic txak;
        logic rsta;
        logic complete;
        logic addressed;
        logic busy;
        logic arb_lost;
        logic slave_rw;
        logic pending;
        logic rx_ack;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } isf_state_t;

    localparam isf_state_t STATE_RESET = '{
        phase: ISF_PH_IDLE,
        scl_prev: ISF_LINE_IDLE[0],
        sda_prev: ISF_LINE_IDLE[1],
        bit_cnt: 4'h0,
        shreg: 8'h00,
        ack_sample: 1'b1,
        own_addr: ISF_OWN_RESET,
        enable: ISF_CTRL_RESET[ISF_CTL_ENABLE],
        int_en: ISF_CTRL_RESET[ISF_CTL_INT_EN],
        master: ISF_CTRL_RESET[ISF_CTL_MASTER],
        tx_sel: ISF_CTRL_RESET[ISF_CTL_TX_SEL],
        txak: ISF_CTRL_RESET[ISF_CTL_TXAK],
        rsta: 1'b0,
        complete: ISF_STATUS_RESET[ISF_ST_COMPLETE],
        addressed: ISF_STATUS_RESET[ISF_ST_ADDRESSED],
        busy: ISF_STATUS_RESET[ISF_ST_BUSY],
        arb_lost: ISF_STATUS_RESET[ISF_ST_ARB_LOST],
        slave_rw: ISF_STATUS_RESET[ISF_ST_SLAVE_RW],
        pending: ISF_STATUS_RESET[ISF_ST_PENDING],
        rx_ack: ISF_STATUS_RESET[ISF_ST_RX_ACK],
        waitreq: 1'b1,
        rdata: 32'h0000_0000,
        irq: 1'b0
    };

    isf_state_t s_q;
    isf_state_t s_d;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;

    // Word decode shared by reads and writes
    function automatic logic addr_hit(logic [31:0] addr, logic [31:0] reg_addr);
        addr_hit = (addr == reg_addr);
    endfunction : addr_hit

    // Pins come from another domain and pass two flops first
    isf_sync2 u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in({sda_in, scl_in}),
        .pin_sync(pins_s)
    );
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];

    // Line events seen at the system clock
    logic scl_rise, scl_fall, start_det, stop_det, in_byte;
    assign scl_rise = scl_s & ~s_q.scl_prev;
    assign scl_fall = ~scl_s & s_q.scl_prev;
    assign start_det = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
    assign stop_det = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;
    assign in_byte = (s_q.phase != ISF_PH_IDLE) & ~start_det & ~stop_det;

    // Bus handshake: a request is taken when waitrequest is low
    logic wr_take, ctl_wr, st_wr, own_wr;
    assign wr_take = avs_write & ~s_q.waitreq & avs_byteenable[0];
    assign ctl_wr = wr_take & addr_hit(avs_address, ISF_ADDR_CTRL);
    assign st_wr = wr_take & addr_hit(avs_address, ISF_ADDR_STATUS);
    assign own_wr = wr_take & addr_hit(avs_address, ISF_ADDR_OWN);

    // Byte boundaries on the serial clock
    logic byte_begin, ninth_fall, addr_match;
    assign byte_begin = in_byte & scl_rise & (s_q.bit_cnt == 4'h0);
    assign ninth_fall = in_byte & scl_fall & (s_q.bit_cnt == ISF_LAST_CLOCK);
    assign addr_match = ninth_fall & s_q.enable &
        (s_q.phase == ISF_PH_ADDR) & (s_q.shreg[7:1] == s_q.own_addr[7:1]);

    // Causes of lost arbitration; only meaningful while enabled
    logic arb_sda, start_busy, rsta_slave, stop_unreq, arb_event;
    assign arb_sda = in_byte & scl_rise & s_q.master & sda_drive_high &
        ~sda_s & (((s_q.bit_cnt < ISF_DATA_BITS) &
        (s_q.tx_sel | (s_q.phase == ISF_PH_ADDR))) |
        ((s_q.bit_cnt == ISF_ACK_BIT) & ~s_q.tx_sel &
        (s_q.phase == ISF_PH_DATA)));
    assign start_busy = ctl_wr & avs_writedata[ISF_CTL_MASTER] &
        ~s_q.master & s_q.busy;
    assign rsta_slave = ctl_wr & avs_writedata[ISF_CTL_RSTA] & ~s_q.master;
    assign stop_unreq = stop_det & s_q.master;
    assign arb_event = s_q.enable &
        (arb_sda | start_busy | rsta_slave | stop_unreq);

    // Next state: software writes first, hardware sets after so sets win
    always_comb begin
        s_d = s_q;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        s_d.rsta = 1'b0;
        s_d.waitreq = 1'b1;
        if ((avs_read | avs_write) & s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata = 32'h0000_0000;
            if (addr_hit(avs_address, ISF_ADDR_STATUS)) begin
                s_d.rdata[ISF_ST_COMPLETE] = s_q.complete;
                s_d.rdata[ISF_ST_ADDRESSED] = s_q.addressed;
                s_d.rdata[ISF_ST_BUSY] = s_q.busy;
                s_d.rdata[ISF_ST_ARB_LOST] = s_q.arb_lost;
                s_d.rdata[ISF_ST_SLAVE_RW] = s_q.slave_rw;
                s_d.rdata[ISF_ST_PENDING] = s_q.pending;
                s_d.rdata[ISF_ST_RX_ACK] = s_q.rx_ack;
            end else if (addr_hit(avs_address, ISF_ADDR_CTRL)) begin
                s_d.rdata[ISF_CTL_ENABLE] = s_q.enable;
                s_d.rdata[ISF_CTL_INT_EN] = s_q.int_en;
                s_d.rdata[ISF_CTL_MASTER] = s_q.master;
                s_d.rdata[ISF_CTL_TX_SEL] = s_q.tx_sel;
                s_d.rdata[ISF_CTL_TXAK] = s_q.txak;
            end else if (addr_hit(avs_address, ISF_ADDR_OWN)) begin
                s_d.rdata[7:1] = s_q.own_addr[7:1];
            end
        end
        if (ctl_wr) begin
            s_d.enable = avs_writedata[ISF_CTL_ENABLE];
            s_d.int_en = avs_writedata[ISF_CTL_INT_EN];
            s_d.master = avs_writedata[ISF_CTL_MASTER];
            s_d.tx_sel = avs_writedata[ISF_CTL_TX_SEL];
            s_d.txak = avs_writedata[ISF_CTL_TXAK];
            s_d.rsta = avs_writedata[ISF_CTL_RSTA] & s_q.master;
            s_d.addressed = 1'b0;
        end
        if (own_wr) begin
            s_d.own_addr = avs_writedata[7:0];
        end
        if (st_wr & ~avs_writedata[ISF_ST_PENDING]) begin
            s_d.pending = 1'b0;
        end
        if (st_wr & ~avs_writedata[ISF_ST_ARB_LOST]) begin
            s_d.arb_lost = 1'b0;
        end

        if (start_det) begin
            s_d.busy = 1'b1;
            s_d.phase = ISF_PH_ADDR;
            s_d.bit_cnt = 4'h0;
        end else if (stop_det) begin
            s_d.busy = 1'b0;
            s_d.phase = ISF_PH_IDLE;
            s_d.bit_cnt = 4'h0;
        end else begin
            unique case (s_q.phase)
                ISF_PH_IDLE: begin
                end
                ISF_PH_ADDR, ISF_PH_DATA: begin
                    if (scl_rise) begin
                        if (s_q.bit_cnt < ISF_DATA_BITS) begin
                            s_d.shreg = {s_q.shreg[6:0], sda_s};
                        end
                        if (s_q.bit_cnt == ISF_ACK_BIT) begin
                            s_d.ack_sample = sda_s;
                        end
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (ninth_fall) begin
                        s_d.bit_cnt = 4'h0;
                        s_d.phase = ISF_PH_DATA;
                    end
                end
                default: begin
                    s_d.phase = ISF_PH_IDLE;
                end
            endcase
        end

        if (byte_begin) begin
            s_d.complete = 1'b0;
        end
        if (ninth_fall & s_q.enable) begin
            s_d.complete = 1'b1;
            s_d.pending = 1'b1;
            s_d.rx_ack = s_q.ack_sample;
        end
        if (addr_match) begin
            s_d.addressed = 1'b1;
            s_d.slave_rw = s_q.shreg[0];
            s_d.pending = 1'b1;
        end
        if (arb_event) begin
            s_d.arb_lost = 1'b1;
            s_d.pending = 1'b1;
            s_d.master = 1'b0;
        end
        s_d.irq = s_q.pending & s_q.int_en;
    end

    // status register resets to complete and no-ack
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign irq = s_q.irq;
    assign ctl_enable = s_q.enable;
    assign ctl_master = s_q.master;
    assign ctl_tx_select = s_q.tx_sel;
    assign ctl_txak = s_q.txak;
    assign repeat_start = s_q.rsta;

    // Checks on the flag behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_done_sets: assert property (ninth_fall && s_q.enable |=> s_q.complete && s_q.pending)
        else $error("ninth clock fall did not set complete and pending");
    a_shift_clears: assert property (byte_begin && !(ninth_fall && s_q.enable) |=> !s_q.complete)
        else $error("complete flag not cleared at byte start");
    a_addr_match: assert property (addr_match |=> s_q.addressed && s_q.slave_rw == $past(s_q.shreg[0]))
        else $error("address match not recorded");
    a_ctl_clears: assert property (ctl_wr && !addr_match |=> !s_q.addressed)
        else $error("control write left addressed flag set");
    a_busy_start: assert property (start_det |=> s_q.busy ##1 s_q.busy || stop_det)
        else $error("busy not set by START");
    a_busy_stop: assert property (stop_det |=> !s_q.busy)
        else $error("busy not cleared by STOP");
    a_arb_sets: assert property (arb_event |=> s_q.arb_lost && s_q.pending && !s_q.master)
        else $error("arbitration loss not flagged");
    a_arb_sticky: assert property (s_q.arb_lost && !st_wr |=> s_q.arb_lost)
        else $error("arbitration lost cleared without a write");
    a_pend_sticky: assert property (s_q.pending && !st_wr |=> s_q.pending)
        else $error("pending cleared without software write");
    a_ie_keeps: assert property ($fell(s_q.int_en) && $past(s_q.pending) && !$past(st_wr) |-> s_q.pending)
        else $error("disabling interrupts cleared pending");
    a_irq_level: assert property (s_q.pending && s_q.int_en |=> irq ##1 irq || !$past(s_q.pending) || !$past(s_q.int_en))
        else $error("interrupt request does not follow pending and enable");
    a_ack_record: assert property (ninth_fall && s_q.enable |=> s_q.rx_ack == $past(s_q.ack_sample))
        else $error("received ack not recorded");
    // Control reads carry the acknowledge bit at bit 3, so only status counts
    a_resv_zero: assert property (!s_q.waitreq &&
        addr_hit(avs_address, ISF_ADDR_STATUS) |->
        s_q.rdata[31:8] == 24'h000000 && !s_q.rdata[3])
        else $error("reserved bits read nonzero");
    a_bus_answer: assert property ((avs_read || avs_write) && s_q.waitreq |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

endmodule : isf_status

`default_nettype wire

//--- isf_pkg.sv
// Constants and types shared by the two-wire status-flag block
package isf_pkg;

    // Register byte addresses on the processor bus
    localparam logic [31:0] ISF_ADDR_OWN = 32'h0021_7000;
    localparam logic [31:0] ISF_ADDR_CTRL = 32'h0021_7008;
    localparam logic [31:0] ISF_ADDR_STATUS = 32'h0021_700c;

    // Status field positions
    localparam int unsigned ISF_ST_COMPLETE = 7;
    localparam int unsigned ISF_ST_ADDRESSED = 6;
    localparam int unsigned ISF_ST_BUSY = 5;
    localparam int unsigned ISF_ST_ARB_LOST = 4;
    localparam int unsigned ISF_ST_SLAVE_RW = 2;
    localparam int unsigned ISF_ST_PENDING = 1;
    localparam int unsigned ISF_ST_RX_ACK = 0;

    // Control field positions
    localparam int unsigned ISF_CTL_ENABLE = 7;
    localparam int unsigned ISF_CTL_INT_EN = 6;
    localparam int unsigned ISF_CTL_MASTER = 5;
    localparam int unsigned ISF_CTL_TX_SEL = 4;
    localparam int unsigned ISF_CTL_TXAK = 3;
    localparam int unsigned ISF_CTL_RSTA = 2;

    // Reset values
    localparam logic [7:0] ISF_STATUS_RESET = 8'h81;
    localparam logic [7:0] ISF_CTRL_RESET = 8'h00;
    localparam logic [7:0] ISF_OWN_RESET = 8'h00;
    localparam logic [1:0] ISF_LINE_IDLE = 2'h3;

    // Bit counts within one byte on the serial bus
    localparam logic [3:0] ISF_DATA_BITS = 4'h8;
    localparam logic [3:0] ISF_ACK_BIT = 4'h8;
    localparam logic [3:0] ISF_LAST_CLOCK = 4'h9;

    // Position of the link within a transfer
    typedef enum logic [1:0] {
        ISF_PH_IDLE = 2'b00,
        ISF_PH_ADDR = 2'b01,
        ISF_PH_DATA = 2'b10
    } isf_phase_t;

endpackage : isf_pkg

//--- isf_sync2.sv
// Two-flop synchroniser for the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none

module isf_sync2 import isf_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
    } isf_sync_t;

    isf_sync_t s_q;
    isf_sync_t s_d;

    // Meta stage feeds only the stable stage
    always_comb begin
        s_d = s_q;
        s_d.meta = pin_in;
        s_d.stable = s_q.meta;
    end

    // Lines idle high, so reset to high avoids a false START
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{meta: ISF_LINE_IDLE, stable: ISF_LINE_IDLE};
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_sync = s_q.stable;

endmodule : isf_sync2

`default_nettype wire

//--- isf_bus_peer.sv
// Behavioural two-wire bus master that drives the serial pins
`timescale 1ns/1ps
`default_nettype none

module isf_bus_peer (
    output var logic scl,
    output var logic sda
);
    // Both lines start driven high, the idle level of the bus
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // START: data falls while the clock is high; the clock then parks low
    task automatic start_cond();
        sda = 1'b1;
        scl = 1'b1;
        #100 sda = 1'b0;
        #100 scl = 1'b0;
    endtask : start_cond

    // Eight bits MSB first and one acknowledge bit, 200 ns per clock
    task automatic send_byte(input logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            #50 scl = 1'b1;
            #100 scl = 1'b0;
            #50;
        end
        sda = ack;
        #50 scl = 1'b1;
        #100 scl = 1'b0;
        #50 sda = 1'b1;
        // Clock stands still low between bytes, data driven back high
    endtask : send_byte

    // STOP: data rises while the clock is high; both lines then idle high
    task automatic stop_cond();
        sda = 1'b0;
        #50 scl = 1'b1;
        #100 sda = 1'b1;
        #100;
    endtask : stop_cond
endmodule : isf_bus_peer
`default_nettype wire

//--- test_i2c_status_flags.sv
// Self-checking bench for the two-wire status-flag block
`timescale 1ns/1ps
`default_nettype none

module test_i2c_status_flags;
    import isf_pkg::*;
    localparam int LIMIT = 20000;
    localparam logic [31:0] ADDR_NONE = 32'h0021_7004;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] avs_address = 32'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sda_drive_high = 1'b0;
    logic irq, ctl_enable, ctl_master, ctl_tx_select, ctl_txak, repeat_start;
    wire logic scl_line;
    wire logic sda_line;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int rsta_seen = 0;

    // 40 MHz system clock
    always #12.5 sys_clk = ~sys_clk;

    isf_bus_peer u_peer (.scl(scl_line), .sda(sda_line));

    isf_status u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .scl_in(scl_line), .sda_in(sda_line),
        .sda_drive_high(sda_drive_high), .irq(irq), .ctl_enable(ctl_enable),
        .ctl_master(ctl_master), .ctl_tx_select(ctl_tx_select),
        .ctl_txak(ctl_txak), .repeat_start(repeat_start)
    );

    // Prints the counts and the verdict, then ends the run
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // A hang is cut short and counted as a mismatch
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            test_done();
        end
    end

    // Repeated START is a one-cycle pulse, so every cycle is counted
    always @(posedge sys_clk) begin
        if (repeat_start === 1'b1) begin
            rsta_seen <= rsta_seen + 1;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [31:0] a,
                            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus_xfer

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus_xfer(1'b1, a, {24'h0, d}, x);
    endtask : wr

    // Read and compare under a mask
    task automatic rd_chk(input string what, input logic [31:0] a,
                          input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] x;
        bus_xfer(1'b0, a, 32'h0, x);
        chk(what, exp, x & mask);
    endtask : rd_chk

    // Let pin changes pass the synchroniser and registered outputs settle
    task automatic settle();
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    // Sends a byte while checking that completion reads clear mid-shift
    task automatic byte_mid(input logic [7:0] b, input logic ack);
        fork
            u_peer.send_byte(b, ack);
            begin
                repeat (20) @(posedge sys_clk);
                rd_chk("complete mid-byte", ISF_ADDR_STATUS, 32'h80, 32'h0);
            end
        join
        settle();
    endtask : byte_mid

    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk("status reset", ISF_ADDR_STATUS, 32'hffffffff, 32'h81);
        rd_chk("control reset", ISF_ADDR_CTRL, 32'hffffffff, 32'h0);
        wr(ADDR_NONE, 8'hff);
        rd_chk("unmapped", ADDR_NONE, 32'hffffffff, 32'h0);
        wr(ISF_ADDR_OWN, 8'h54);
        wr(ISF_ADDR_CTRL, 8'hc0);
        u_peer.start_cond();
        settle();
        rd_chk("busy on start", ISF_ADDR_STATUS, 32'hffffffff, 32'ha1);
        // Address 0x2a with read direction, acknowledged; mid-byte
        byte_mid(8'h55, 1'b0);
        rd_chk("address match", ISF_ADDR_STATUS, 32'hffffffff, 32'he6);
        chk("irq on match", 32'h1, {31'h0, irq});
        // Software follows the direction flag into transmit select
        wr(ISF_ADDR_CTRL, 8'hd0);
        rd_chk("control write", ISF_ADDR_STATUS, 32'hffffffff, 32'ha6);
        chk("tx select", 32'h1, {31'h0, ctl_tx_select});
        wr(ISF_ADDR_CTRL, 8'h98);
        settle();
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk("pending kept", ISF_ADDR_STATUS, 32'hffffffff, 32'ha6);
        rd_chk("control read", ISF_ADDR_CTRL, 32'hffffffff, 32'h98);
        chk("txak out", 32'h1, {31'h0, ctl_txak});
        chk("enable out", 32'h1, {31'h0, ctl_enable});
        wr(ISF_ADDR_STATUS, 8'hff);
        rd_chk("write ones", ISF_ADDR_STATUS, 32'hffffffff, 32'ha6);
        wr(ISF_ADDR_STATUS, 8'h00);
        rd_chk("pending clear", ISF_ADDR_STATUS, 32'hffffffff, 32'ha4);
        wr(ISF_ADDR_CTRL, 8'hc0);
        // Data byte with no acknowledge; direction flag is not valid here
        byte_mid(8'h3c, 1'b1);
        rd_chk("no ack", ISF_ADDR_STATUS, 32'hfffffffb, 32'ha3);
        chk("irq on byte", 32'h1, {31'h0, irq});
        u_peer.stop_cond();
        settle();
        rd_chk("idle on stop", ISF_ADDR_STATUS, 32'h20, 32'h0);
        wr(ISF_ADDR_STATUS, 8'h00);
        wr(ISF_ADDR_CTRL, 8'hc4);
        settle();
        rd_chk("slave restart", ISF_ADDR_STATUS, 32'h12, 32'h12);
        wr(ISF_ADDR_STATUS, 8'h00);
        rd_chk("arb clear", ISF_ADDR_STATUS, 32'h12, 32'h0);
        wr(ISF_ADDR_CTRL, 8'he0);
        settle();
        chk("master set", 32'h1, {31'h0, ctl_master});
        // Repeated START while master pulses once; the slave attempt did not
        wr(ISF_ADDR_CTRL, 8'he4);
        settle();
        chk("repeat start", 32'h1, rsta_seen);
        rd_chk("restart reads 0", ISF_ADDR_CTRL, 32'hffffffff, 32'he0);
        u_peer.start_cond();
        @(posedge sys_clk);
        sda_drive_high <= 1'b1;
        u_peer.send_byte(8'h00, 1'b0);
        @(posedge sys_clk);
        sda_drive_high <= 1'b0;
        settle();
        rd_chk("data low lost", ISF_ADDR_STATUS, 32'h12, 32'h12);
        chk("master dropped", 32'h0, {31'h0, ctl_master});
        wr(ISF_ADDR_STATUS, 8'h00);
        wr(ISF_ADDR_CTRL, 8'he0);
        settle();
        rd_chk("start on busy", ISF_ADDR_STATUS, 32'h12, 32'h12);
        chk("master busy", 32'h0, {31'h0, ctl_master});
        u_peer.stop_cond();
        wr(ISF_ADDR_STATUS, 8'h00);
        // The clock rise ahead of STOP counts as a byte start and clears complete
        rd_chk("final", ISF_ADDR_STATUS, 32'hffffffff, 32'h04);
        test_done();
    end
endmodule : test_i2c_status_flags
`default_nettype wire
